// ### rtl/adc_seq_pkg.sv
// shared constants and carrier types for the converter sequencer
package adc_seq_pkg;
    // register map (word addresses on the plain port)
    localparam logic [3:0] ADDR_CTRL_STATUS = 4'h0;
    localparam logic [3:0] ADDR_TRIG_CTRL = 4'h1;
    localparam logic [3:0] ADDR_RESULT_0 = 4'h2;
    // control/status field positions
    localparam int DONE_BIT = 7;
    localparam int IRQ_EN_BIT = 6;
    localparam int GO_BIT = 5;
    localparam int SWEEP_BIT = 4;
    localparam int SPEED_BIT = 3;
    localparam int GROUP_BIT = 2;
    // trigger control layout, register reset values and trigger sources
    localparam int TRIG_HI_BIT = 7;
    localparam int TRIG_LO_BIT = 6;
    localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
    localparam logic [5:0] TRIG_RSVD_RESET = 6'h3F;
    localparam logic [1:0] TRIG_NONE = 2'h0;
    localparam logic [1:0] TRIG_TIMER = 2'h2;
    localparam logic [1:0] TRIG_PIN = 2'h3;
    // conversion lengths in states, result width and result shift
    localparam int SLOW_STATES = 266;
    localparam int FAST_STATES = 134;
    localparam int RESULT_BITS = 10;
    localparam int RESULT_SHIFT = 6;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic start;
        logic [2:0] channel;
        logic fast;
    } core_cmd_t;
endpackage

// ### rtl/adc_sequencer_control.sv
// sequencer and register file for the eight-input converter
//
// Design decisions made here: the strobed register port and the register offsets.
module adc_sequencer_control #(
    parameter int SLOW_LEN = adc_seq_pkg::SLOW_STATES,
    parameter int FAST_LEN = adc_seq_pkg::FAST_STATES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // register port
    input wire adc_seq_pkg::bus_req_t bus,
    output logic [15:0] rd_data,
    // triggers
    input wire logic timer_trigger,
    input wire logic external_trigger_pin_n,
    // analog core
    output adc_seq_pkg::core_cmd_t core_cmd,
    input wire logic core_done,
    input wire logic [9:0] core_result,
    // status
    output logic done_interrupt,
    output logic busy
);
    typedef enum logic [1:0] {IDLE, LAUNCH, WAIT_CORE} phase_t;

    typedef struct packed {
        logic [7:0] csr;
        logic [1:0] trig_src;
        logic [5:0] trig_rsvd;
        logic [3:0][9:0] result;
        phase_t phase;
        logic [2:0] chan;
        logic pin_prev;
        logic [15:0] rdata;
        logic start;
        logic irq;
    } state_t;

    state_t s_q;
    state_t s_d;

    // result word as software sees it
    function automatic logic [15:0] result_word(input logic [9:0] v);
        result_word = {v, 6'h00};
    endfunction

    // last input of the selected span
    function automatic logic [2:0] span_last(input logic [2:0] sel);
        span_last = sel;
    endfunction

    logic go;
    logic sweep;
    logic hw_start;
    logic sw_go_set;
    logic wr_csr;

    assign go = s_q.csr[adc_seq_pkg::GO_BIT];
    assign sweep = s_q.csr[adc_seq_pkg::SWEEP_BIT];
    assign wr_csr = bus.wr && bus.addr == adc_seq_pkg::ADDR_CTRL_STATUS;
    assign sw_go_set = wr_csr && bus.wdata[adc_seq_pkg::GO_BIT];

    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        hw_start = 1'b0;
        s_d.pin_prev = external_trigger_pin_n;
        if (s_q.trig_src == adc_seq_pkg::TRIG_TIMER) begin
            hw_start = timer_trigger;
        end else if (s_q.trig_src == adc_seq_pkg::TRIG_PIN) begin
            hw_start = s_q.pin_prev && !external_trigger_pin_n;
        end

        // register writes; software owns mode bits only while idle by contract
        if (wr_csr) begin
            s_d.csr[adc_seq_pkg::DONE_BIT] = s_q.csr[adc_seq_pkg::DONE_BIT]
                && bus.wdata[adc_seq_pkg::DONE_BIT];
            s_d.csr[6:0] = bus.wdata[6:0];
        end else if (bus.wr && bus.addr == adc_seq_pkg::ADDR_TRIG_CTRL) begin
            s_d.trig_src = bus.wdata[adc_seq_pkg::TRIG_HI_BIT:adc_seq_pkg::TRIG_LO_BIT];
            s_d.trig_rsvd = bus.wdata[5:0];
        end
        // hardware start acts like software go
        if (hw_start) begin
            s_d.csr[adc_seq_pkg::GO_BIT] = 1'b1;
        end

        case (s_q.phase)
            IDLE: begin
                // new settings take effect with this start
                if (s_d.csr[adc_seq_pkg::GO_BIT]) begin
                    if (s_d.csr[adc_seq_pkg::SWEEP_BIT]) begin
                        s_d.chan = {s_d.csr[adc_seq_pkg::GROUP_BIT], 2'b00};
                    end else begin
                        s_d.chan = s_d.csr[2:0];
                    end
                    s_d.phase = LAUNCH;
                end
            end
            LAUNCH: begin
                s_d.start = 1'b1;
                s_d.phase = WAIT_CORE;
            end
            WAIT_CORE: begin
                if (core_done) begin
                    s_d.result[s_q.chan[1:0]] = core_result;
                    if (!sweep) begin
                        s_d.csr[adc_seq_pkg::DONE_BIT] = 1'b1;
                        s_d.csr[adc_seq_pkg::GO_BIT] = 1'b0;
                        s_d.phase = IDLE;
                    end else if (!s_d.csr[adc_seq_pkg::GO_BIT]) begin
                        s_d.phase = IDLE;
                    end else begin
                        if (s_q.chan == span_last(s_q.csr[2:0])) begin
                            s_d.csr[adc_seq_pkg::DONE_BIT] = 1'b1;
                            s_d.chan = {s_q.csr[adc_seq_pkg::GROUP_BIT], 2'b00};
                        end else begin
                            s_d.chan = s_q.chan + 3'h1;
                        end
                        s_d.phase = LAUNCH;
                    end
                end else if (sweep && !s_d.csr[adc_seq_pkg::GO_BIT]) begin
                    // stop mid-conversion drops the pending result
                    s_d.phase = IDLE;
                end
            end
            default: s_d.phase = IDLE;
        endcase

        s_d.irq = s_d.csr[adc_seq_pkg::DONE_BIT] && s_d.csr[adc_seq_pkg::IRQ_EN_BIT];

        s_d.rdata = 16'h0000;
        if (bus.rd) begin
            if (bus.addr == adc_seq_pkg::ADDR_CTRL_STATUS) begin
                s_d.rdata = {8'h00, s_q.csr};
            end else if (bus.addr == adc_seq_pkg::ADDR_TRIG_CTRL) begin
                s_d.rdata = {8'h00, s_q.trig_src, s_q.trig_rsvd};
            end else if (bus.addr >= adc_seq_pkg::ADDR_RESULT_0
                         && bus.addr < adc_seq_pkg::ADDR_RESULT_0 + 4'h4) begin
                s_d.rdata = result_word(s_q.result[2'(bus.addr - adc_seq_pkg::ADDR_RESULT_0)]);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.csr <= adc_seq_pkg::CTRL_STATUS_RESET;
            s_q.trig_rsvd <= adc_seq_pkg::TRIG_RSVD_RESET;
            s_q.trig_src <= adc_seq_pkg::TRIG_NONE;
            s_q.phase <= IDLE;
            s_q.pin_prev <= 1'b1;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rdata;
    assign done_interrupt = s_q.irq;
    assign busy = s_q.phase != IDLE;
    assign core_cmd.fast = s_q.csr[adc_seq_pkg::SPEED_BIT];
    assign core_cmd.start = s_q.start;
    assign core_cmd.channel = s_q.chan;
endmodule

// ### testbench/adc_seq_properties.sv
// port-level properties of the converter sequencer
module adc_seq_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched ports
    input wire adc_seq_pkg::bus_req_t bus,
    input wire logic [15:0] rd_data,
    input wire adc_seq_pkg::core_cmd_t core_cmd,
    input wire logic core_done,
    input wire logic done_interrupt,
    input wire logic busy
);
    logic sweep_q;
    logic cs_wr;
    assign cs_wr = bus.wr && bus.addr == adc_seq_pkg::ADDR_CTRL_STATUS;
    // mode copy, only trusted while software obeys the idle rule
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) sweep_q <= 1'b0;
        else if (cs_wr) sweep_q <= bus.wdata[adc_seq_pkg::SWEEP_BIT];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_START_PULSE: assert property (core_cmd.start |=> !core_cmd.start)
        else $error("start strobe longer than one cycle");
    AST_GO_LAUNCH: assert property (cs_wr && bus.wdata[5] && !busy |-> ##2 core_cmd.start)
        else $error("go write did not launch");
    AST_IRQ_CLEAR: assert property (cs_wr && !bus.wdata[7] && !core_done ##1 !core_done
        |-> ##1 !done_interrupt) else $error("interrupt survived clear");
    AST_CHAN_HOLD: assert property ($changed(core_cmd.channel) |=> core_cmd.start)
        else $error("channel moved without start");
    AST_RESULT_LSB: assert property ($past(bus.rd) && $past(bus.addr) inside {[2:5]}
        |-> rd_data[5:0] == 6'h00) else $error("result low bits not zero");
    AST_BUSY_START: assert property (core_cmd.start |-> busy)
        else $error("start while idle");
    AST_SCAN_NEXT: assert property (busy && core_done && sweep_q && !cs_wr ##1 !cs_wr
        |-> ##1 core_cmd.start) else $error("scan did not continue");
    AST_SINGLE_END: assert property (core_done && !sweep_q |-> ##[1:2] !busy)
        else $error("single conversion did not end");
endmodule

// ### testbench/tb_adc_sequencer_control.sv
// self-checking bench for the converter sequencer
module tb_adc_sequencer_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    adc_seq_pkg::bus_req_t bus = '0;
    logic [15:0] rd_data;
    adc_seq_pkg::core_cmd_t core_cmd;
    logic core_done = 1'b0;
    logic [9:0] core_result = '0;
    logic done_interrupt, busy, last_fast;
    logic timer_trigger = 1'b0;
    logic ext_n = 1'b1;
    logic [2:0] cur, chq[$];
    logic [7:0] cfg;
    int n_mismatch = 0, cmp_count = 0, dly = 0;
    always #50 clk = ~clk;
    adc_sequencer_control adc_sequencer_control_i (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
        .bus(bus), .rd_data(rd_data), .timer_trigger(timer_trigger),
        .external_trigger_pin_n(ext_n), .core_cmd(core_cmd), .core_done(core_done),
        .core_result(core_result), .done_interrupt(done_interrupt), .busy(busy));
    // core stand-in: result is garbage except in the done cycle
    always @(posedge clk) begin
        core_done <= dly == 1;
        core_result <= dly == 1 ? {cur, 7'h55} : ~core_result;
        if (dly > 0) dly <= dly - 1;
        if (core_cmd.start === 1'b1) begin
            chq.push_back(core_cmd.channel);
            cur <= core_cmd.channel;
            last_fast <= core_cmd.fast;
            dly <= 4;
        end
    end
    function automatic logic [15:0] res(input logic [2:0] c);
        return {c, 7'h55, 6'h00};
    endfunction
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 chk(rd_data, exp);
        @(posedge clk);
    endtask
    task automatic wait_idle;
        int i;
        for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
        if (i == 400) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t sequencer hung", $time);
            conclude();
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(adc_seq_pkg::ADDR_CTRL_STATUS, 16'h0000);
        rd(adc_seq_pkg::ADDR_TRIG_CTRL, 16'h003F);
        rd(4'hF, 16'h0000);
        $display("reset test done");
        for (int c = 0; c < 8; c++) begin
            cfg = 8'(c) | (c[0] ? 8'h08 : 8'h00);
            wr(adc_seq_pkg::ADDR_CTRL_STATUS, cfg | 8'h20);
            wait_idle();
            rd(adc_seq_pkg::ADDR_CTRL_STATUS, {8'h00, cfg | 8'h80});
            rd(adc_seq_pkg::ADDR_RESULT_0 + 4'(c % 4), res(3'(c)));
            chk({15'h0, last_fast}, {15'h0, c[0]});
            chk({13'h0, chq.pop_back()}, 16'(c));
        end
        wr(adc_seq_pkg::ADDR_CTRL_STATUS, 8'h87);
        rd(adc_seq_pkg::ADDR_CTRL_STATUS, 16'h0087);
        wr(adc_seq_pkg::ADDR_CTRL_STATUS, 8'h60);
        wait_idle();
        chk({15'h0, done_interrupt}, 16'h0001);
        wr(adc_seq_pkg::ADDR_CTRL_STATUS, 8'h40);
        rd(adc_seq_pkg::ADDR_CTRL_STATUS, 16'h0040);
        chk({15'h0, done_interrupt}, 16'h0000);
        $display("single test done");
        chq.delete();
        wr(adc_seq_pkg::ADDR_CTRL_STATUS, 8'h37);
        for (int i = 0; i < 400 && chq.size() < 5; i++) @(posedge clk);
        if (chq.size() < 5) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t scan stalled", $time);
            conclude();
        end
        rd(adc_seq_pkg::ADDR_CTRL_STATUS, 16'h00B7);
        wr(adc_seq_pkg::ADDR_CTRL_STATUS, 8'h17);
        wait_idle();
        chk(16'(chq.size()) & 16'h00F8, 16'h0000);
        for (int i = 0; i < 5; i++) chk({13'h0, chq[i]}, 16'(4 + i % 4));
        for (int i = 0; i < 4; i++) rd(4'(2 + i), res(3'(4 + i)));
        $display("scan test done");
        for (int s = 0; s < 4; s++) begin
            wr(adc_seq_pkg::ADDR_TRIG_CTRL, {2'(s), 6'h3F});
            rd(adc_seq_pkg::ADDR_TRIG_CTRL, {8'h00, 2'(s), 6'h3F});
            wr(adc_seq_pkg::ADDR_CTRL_STATUS, 8'h01);
            timer_trigger <= 1'b1;
            ext_n <= 1'b0;
            @(posedge clk);
            timer_trigger <= 1'b0;
            repeat (3) @(posedge clk);
            wait_idle();
            ext_n <= 1'b1;
            rd(adc_seq_pkg::ADDR_CTRL_STATUS, s > 1 ? 16'h0081 : 16'h0001);
        end
        $display("trigger test done");
        conclude();
    end
endmodule
bind adc_sequencer_control adc_seq_properties adc_seq_properties_i (.clk(clk), .rst_n(rst_n),
    .bus(bus), .rd_data(rd_data), .core_cmd(core_cmd), .core_done(core_done),
    .done_interrupt(done_interrupt), .busy(busy));
